// ---- mior_pkg.sv ----
// Package: constants and carriers for the mixed I/O register block
package mior_pkg;
    // ------------------------------------------------------------
    // Register numbers for acyclic access
    // ------------------------------------------------------------
    localparam logic [7:0] REG_INPUT_STATE = 8'h00;
    localparam logic [7:0] REG_OUTPUT_SWITCH = 8'h02;
    localparam logic [7:0] REG_INPUT_FILTER = 8'h12;
    localparam logic [7:0] REG_OUTPUT_FAULT = 8'h1e;
    // ------------------------------------------------------------
    // Cyclic frame offsets, standard model
    // ------------------------------------------------------------
    localparam logic [7:0] STD_OFS_OUTPUT = 8'h00;
    localparam logic [7:0] STD_OFS_INPUT = 8'h01;
    localparam logic [7:0] STD_OFS_FAULT = 8'h02;
    // ------------------------------------------------------------
    // Bus-controller model: byte positions in the CAN objects
    // ------------------------------------------------------------
    localparam logic [7:0] BC_MODEL = 8'hfe;
    localparam logic [7:0] BC_OFS_INPUT = 8'h00;
    localparam logic [7:0] BC_OFS_OUTPUT = 8'h00;
    // ------------------------------------------------------------
    // Filter setting and timing
    // ------------------------------------------------------------
    localparam logic [7:0] FILTER_MAX = 8'hfa;
    localparam logic [7:0] FILTER_RESET = 8'h00;
    localparam logic [3:0] OUTPUT_RESET = 4'h0;
    localparam logic [3:0] FAULT_RESET = 4'h0;
    localparam int CLK_MHZ = 100;
    localparam int FILTER_STEP_US = 100;
    localparam int FILTER_STEP_CYC = FILTER_STEP_US * CLK_MHZ;
    localparam int FLASH_ON_MS = 200;
    localparam int FLASH_PERIOD_MS = 1200;
    localparam int FLASH_ON_CYC = FLASH_ON_MS * 1000 * CLK_MHZ;
    localparam int FLASH_PERIOD_CYC = FLASH_PERIOD_MS * 1000 * CLK_MHZ;

    // Access kind on the controller port
    typedef enum logic [1:0] {
        MIOR_ACC_IDLE = 2'b00,
        MIOR_ACC_CYCLIC = 2'b01,
        MIOR_ACC_ACYCLIC = 2'b10
    } mior_acc_t;

    // One request from the bus controller
    typedef struct packed {
        mior_acc_t kind;
        logic write;
        logic [7:0] addr;
        logic [7:0] wdata;
    } mior_req_t;

    // One answer to the bus controller
    typedef struct packed {
        logic valid;
        logic [7:0] rdata;
    } mior_rsp_t;
endpackage

// ---- mior_top.sv ----
// Module: mixed I/O register map with channel indicators
`timescale 1ns/100ps
`default_nettype none

//
// Contract
// - Red indicator dark without channel faults
// - Red single flash on any channel fault
// - Green indicators follow eight input states
// - Orange indicators follow four output states
// - Input byte at register 0, bits 0-7
// - Output byte written at register 2, bits 0-3
// - Fault bits in register 30, bits 0-3
// - Acyclic by register; filter only acyclic write
// - Standard cyclic offsets: out 0, in 1, fault 2
// - Model 254: in/out at object byte 0
// - Fault on overload, no power, foreign voltage
// - Filter in 100 us units, clamp at 250
// - Output change clears its monitoring state
module mior_top #(
    // Channel counts
    parameter int N_IN = 8,
    parameter int N_OUT = 4,
    // Timing in clock cycles; small values keep simulation short
    parameter int FILTER_STEP = mior_pkg::FILTER_STEP_CYC,
    parameter int FLASH_ON = mior_pkg::FLASH_ON_CYC,
    parameter int FLASH_PERIOD = mior_pkg::FLASH_PERIOD_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Function model select
    input wire logic [7:0] func_model,
    // Controller request and answer
    input wire mior_pkg::mior_req_t req,
    output mior_pkg::mior_rsp_t rsp,
    // Field pins
    input wire logic [N_IN-1:0] din,
    output logic [N_OUT-1:0] dout,
    // Output monitor causes per channel
    input wire logic [N_OUT-1:0] mon_overload,
    input wire logic [N_OUT-1:0] mon_no_power,
    input wire logic [N_OUT-1:0] mon_ext_volt,
    // Indicators
    output logic led_red,
    output logic [N_IN-1:0] led_green,
    output logic [N_OUT-1:0] led_orange,
    // Clamped filter setting as it stands
    output logic [7:0] filter_eff
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [N_OUT-1:0] out_reg, out_next;        // Commanded switching
    logic [N_OUT-1:0] fault_reg, fault_next;    // Sticky fault bits
    logic [7:0] filter_reg, filter_next;        // Clamped filter setting
    logic [N_IN-1:0] in_reg;                    // Filtered input state
    logic [31:0] step_reg;                      // 100 us prescaler
    logic [31:0] flash_reg;                     // Flash pattern timer
    mior_pkg::mior_rsp_t rsp_reg;               // Registered answer
    // Per-pin filter counters are declared inside the generate loop

    // ------------------------------------------------------------
    // Request decoding
    // ------------------------------------------------------------
    // Model select is a level, read afresh for every request
    wire is_bc = (func_model == mior_pkg::BC_MODEL);
    wire cyc = (req.kind == mior_pkg::MIOR_ACC_CYCLIC);
    wire acyc = (req.kind == mior_pkg::MIOR_ACC_ACYCLIC);
    // Cyclic offsets depend on model; CAN input and output objects are
    // separate, so both sit at byte 0 and direction tells them apart
    wire [7:0] ofs_in = is_bc ? mior_pkg::BC_OFS_INPUT : mior_pkg::STD_OFS_INPUT;
    wire [7:0] ofs_out = is_bc ? mior_pkg::BC_OFS_OUTPUT : mior_pkg::STD_OFS_OUTPUT;
    // Input byte by frame offset
    wire cyc_rd_in = cyc && !req.write && req.addr == ofs_in;
    // Fault byte is cyclic only in the standard model
    wire cyc_rd_fault = cyc && !req.write && !is_bc && req.addr == mior_pkg::STD_OFS_FAULT;
    // Output write by frame offset in either model
    wire cyc_wr_out = cyc && req.write && req.addr == ofs_out;
    // Acyclic access goes by register number
    wire acy_rd_in = acyc && !req.write && req.addr == mior_pkg::REG_INPUT_STATE;
    wire acy_rd_fault = acyc && !req.write && req.addr == mior_pkg::REG_OUTPUT_FAULT;
    wire acy_wr_out = acyc && req.write && req.addr == mior_pkg::REG_OUTPUT_SWITCH;
    // Filter is reachable by acyclic write only
    wire acy_wr_filt = acyc && req.write && req.addr == mior_pkg::REG_INPUT_FILTER;
    // Both paths may write the outputs; the filter has no cyclic path
    wire wr_out = cyc_wr_out || acy_wr_out;
    wire [N_OUT-1:0] new_out = req.wdata[N_OUT-1:0];
    wire [7:0] filt_clamped = (req.wdata > mior_pkg::FILTER_MAX) ? mior_pkg::FILTER_MAX
                                                                 : req.wdata;
    // Bits whose commanded state flips with this write
    wire [N_OUT-1:0] changed = wr_out ? (new_out ^ out_reg) : '0;
    // Each cause of a fault; no power and foreign voltage qualified by commanded state, overload always counts
    wire [N_OUT-1:0] cause = mon_overload | (out_reg & mon_no_power)
                           | (~out_reg & mon_ext_volt);
    // Unused upper bits of the fault byte read as zero
    wire [7:0] fault_byte = {{(8-N_OUT){1'b0}}, fault_reg};
    wire [7:0] in_byte = in_reg;
    // One filter step has elapsed
    wire step_tick = (step_reg >= 32'(FILTER_STEP - 1));

    // ------------------------------------------------------------
    // Next-state selection
    // ------------------------------------------------------------
    // Outputs hold until the controller writes them
    assign out_next = wr_out ? new_out : out_reg;
    // Monitoring restarts on a change; a fresh cause still wins
    assign fault_next = (fault_reg & ~changed) | cause;
    // Clamping happens on the way in, so the register never holds more
    assign filter_next = acy_wr_filt ? filt_clamped : filter_reg;

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    // Reset leaves outputs off, faults clear and the filter bypassed
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            out_reg <= mior_pkg::OUTPUT_RESET;
            fault_reg <= mior_pkg::FAULT_RESET;
            filter_reg <= mior_pkg::FILTER_RESET;
        end else begin
            out_reg <= out_next;
            fault_reg <= fault_next;
            filter_reg <= filter_next;
        end
    end

    // ------------------------------------------------------------
    // Input filter: per-channel debounce in 100 us steps
    // ------------------------------------------------------------
    // Shared prescaler: the first step after a pin starts to differ may be
    // partial, so the delay can fall short of the setting by up to one step
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            step_reg <= '0;
        end else begin
            step_reg <= step_tick ? 32'h0 : step_reg + 32'h1;
        end
    end

    // One debounce counter per input pin
    genvar gi;
    generate
        for (gi = 0; gi < N_IN; gi++) begin : g_filt
            logic [7:0] cnt_reg;  // Steps the pin has differed
            // Zero setting passes the pin straight through
            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    cnt_reg <= 8'h00;
                    in_reg[gi] <= 1'b0;
                end else if (filter_reg == 8'h00) begin
                    cnt_reg <= 8'h00;
                    in_reg[gi] <= din[gi];
                end else if (din[gi] == in_reg[gi]) begin
                    // Pin agrees again: restart the count
                    cnt_reg <= 8'h00;
                end else if (step_tick) begin
                    if (cnt_reg + 8'h01 >= filter_reg) begin
                        in_reg[gi] <= din[gi];
                        cnt_reg <= 8'h00;
                    end else begin
                        cnt_reg <= cnt_reg + 8'h01;
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Answer path: one-cycle registered read data
    // ------------------------------------------------------------
    // Writes and unmapped reads still answer, with zero data
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rsp_reg <= '0;
        end else begin
            rsp_reg.valid <= cyc || acyc;
            if (cyc_rd_in || acy_rd_in) begin
                rsp_reg.rdata <= in_byte;
            end else if (cyc_rd_fault || acy_rd_fault) begin
                rsp_reg.rdata <= fault_byte;
            end else begin
                rsp_reg.rdata <= 8'h00;   // Unmapped or write
            end
        end
    end

    // ------------------------------------------------------------
    // Red indicator single-flash timer
    // ------------------------------------------------------------
    // Timer runs freely; pattern only shown while a fault stands
    // A fault raised mid-period may show a shortened first flash
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            flash_reg <= '0;
            led_red <= 1'b0;
        end else begin
            flash_reg <= (flash_reg >= 32'(FLASH_PERIOD - 1)) ? 32'h0 : flash_reg + 32'h1;
            led_red <= (|fault_reg) && (flash_reg < 32'(FLASH_ON));
        end
    end

    // ------------------------------------------------------------
    // Pin and indicator outputs, all registered
    // ------------------------------------------------------------
    // Pins use the next value, so they follow a write after one cycle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dout <= '0;
            led_green <= '0;
            led_orange <= '0;
            filter_eff <= 8'h00;
        end else begin
            dout <= out_next;
            led_green <= in_reg;
            led_orange <= out_next;
            // Stored setting, two cycles behind the write request
            filter_eff <= filter_reg;
        end
    end

    // Answer leaves straight from its register
    assign rsp = rsp_reg;
endmodule

`default_nettype wire

// ---- mior_top_props.sv ----
// Checker for the mixed I/O register block
`timescale 1ns/100ps
`default_nettype none
module mior_top_props (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Controller side
    input wire mior_pkg::mior_req_t req,
    input wire mior_pkg::mior_rsp_t rsp,
    // Outputs and setting
    input wire logic [3:0] dout,
    input wire logic [3:0] led_orange,
    input wire logic [7:0] filter_eff
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // Any request is answered exactly one cycle later
    chk_rsp_one_late: assert property (req.kind != 2'b00 |=> rsp.valid)
        else $error("request without answer");
    chk_idle_silent: assert property (req.kind == 2'b00 |=> !rsp.valid)
        else $error("answer without request");
    // Orange indicators track the driven outputs
    chk_orange_mirror: assert property (led_orange == dout)
        else $error("orange indicators differ from outputs");
    // Output byte: acyclic register 2 or cyclic offset 0
    chk_out_write: assert property (req.write && ((req.kind == 2'b10 && req.addr == 8'h02)
        || (req.kind == 2'b01 && req.addr == 8'h00)) |=> dout == $past(req.wdata[3:0]))
        else $error("output byte not taken");
    // The setting reaches filter_eff two cycles after the request
    chk_filter_clamp: assert property (req.kind == 2'b10 && req.write && req.addr == 8'h12
        |=> ##1 filter_eff == ($past(req.wdata, 2) > 8'hfa ? 8'hfa : $past(req.wdata, 2)))
        else $error("filter setting wrong");
    // Cyclic traffic must never touch the filter
    chk_filter_cyclic: assert property (req.kind == 2'b01 |=> ##1 $stable(filter_eff))
        else $error("filter changed by cyclic write");
    chk_unmapped_zero: assert property (req.kind == 2'b10 && req.addr == 8'h05
        |=> rsp.rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_reset_clear: assert property ($rose(rstn) |-> dout == 4'h0 && filter_eff == 8'h00)
        else $error("state not cleared by reset");
endmodule
bind mior_top mior_top_props chk_u (.clk(clk), .rstn(rstn), .req(req), .rsp(rsp), .dout(dout),
    .led_orange(led_orange), .filter_eff(filter_eff));
`default_nettype wire

// ---- mior_ctrl_model.sv ----
// Bus controller model issuing cyclic and acyclic requests
`timescale 1ns/100ps
`default_nettype none
module mior_ctrl_model (
    // Clock
    input wire logic clk,
    // Request out, answer in
    output mior_pkg::mior_req_t req,
    input wire mior_pkg::mior_rsp_t rsp
);
    initial req = '0;
    // Cyclic uses frame offsets, acyclic register numbers
    task automatic xfer(input mior_pkg::mior_acc_t k, input logic w, input logic [7:0] a,
        input logic [7:0] d, output logic [7:0] q, output logic v);
        @(posedge clk);
        req <= '{k, w, a, d};
        @(posedge clk);
        // Idle fields inverted so stale values are never trusted
        req <= '{mior_pkg::MIOR_ACC_IDLE, ~w, ~a, ~d};
        #1;
        q = rsp.rdata;
        v = rsp.valid;
    endtask
endmodule
`default_nettype wire

// ---- mior_top_tb_top.sv ----
// Self-checking bench for the mixed I/O register block
`timescale 1ns/100ps
`default_nettype none
module mior_top_tb_top;
    localparam mior_pkg::mior_acc_t C = mior_pkg::MIOR_ACC_CYCLIC;
    localparam mior_pkg::mior_acc_t A = mior_pkg::MIOR_ACC_ACYCLIC;
    // Row: model, kind, write, addr, wdata, din, expected rdata and outputs
    typedef struct packed {
        logic [7:0] fm;
        mior_pkg::mior_acc_t k;
        logic w;
        logic [7:0] a, d, di, q;
        logic [3:0] o;
    } mior_row_t;
    mior_row_t rows [9] = '{'{8'h00, C, 1'b1, 8'h00, 8'h1a, 8'ha5, 8'h00, 4'ha},
        '{8'h00, C, 1'b0, 8'h01, 8'h00, 8'ha5, 8'ha5, 4'ha}, '{8'h00, A, 1'b1, 8'h02, 8'h15, 8'ha5, 8'h00, 4'h5},
        '{8'h00, A, 1'b0, 8'h02, 8'h00, 8'ha5, 8'h00, 4'h5}, '{8'hfe, C, 1'b0, 8'h00, 8'h00, 8'h3c, 8'h3c, 4'h5},
        '{8'hfe, C, 1'b1, 8'h00, 8'h09, 8'h3c, 8'h00, 4'h9}, '{8'h00, A, 1'b0, 8'h05, 8'h00, 8'h3c, 8'h00, 4'h9},
        '{8'h00, C, 1'b0, 8'h02, 8'h00, 8'h3c, 8'h00, 4'h9}, '{8'h00, A, 1'b1, 8'h00, 8'hff, 8'h3c, 8'h00, 4'h9}};
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] fm = 8'h00, din = 8'h00, green, filt, q;
    logic [3:0] m_ov = 4'h0, m_np = 4'h0, m_ev = 4'h0, dout, orange;
    logic red, v;
    mior_pkg::mior_req_t req;
    mior_pkg::mior_rsp_t rsp;
    int errors = 0, checks = 0, cnt;
    // Free-running 100 MHz clock
    always #5 clk = ~clk;
    mior_ctrl_model ctl_u (.clk(clk), .req(req), .rsp(rsp));
    mior_top #(.FILTER_STEP(4), .FLASH_ON(3), .FLASH_PERIOD(10)) dut_u (.clk(clk), .rstn(rstn),
        .func_model(fm), .req(req), .rsp(rsp), .din(din), .dout(dout), .mon_overload(m_ov),
        .mon_no_power(m_np), .mon_ext_volt(m_ev), .led_red(red), .led_green(green),
        .led_orange(orange), .filter_eff(filt));
    // Compare and count
    task automatic check(input string n, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %s expected %h seen %h", n, exp, got);
        end
    endtask
    // Count lit cycles of the red indicator
    task automatic count_red();
        cnt = 0;
        repeat (30) begin
            @(posedge clk);
            cnt += (red === 1'b1);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        #1;
        check("dout", 8'h00, {4'h0, dout});
        check("filter", 8'h00, filt);
        check("red", 8'h00, {7'h0, red});
        for (int i = 0; i < 9; i++) begin
            @(posedge clk);
            fm <= rows[i].fm;
            din <= rows[i].di;
            repeat (3) @(posedge clk);
            ctl_u.xfer(rows[i].k, rows[i].w, rows[i].a, rows[i].d, q, v);
            check("valid", 8'h01, {7'h0, v});
            check("rdata", rows[i].q, q);
            check("dout", {4'h0, rows[i].o}, {4'h0, dout});
            check("green", rows[i].di, green);
            check("orange", {4'h0, rows[i].o}, {4'h0, orange});
        end
        $display("rows done");
        ctl_u.xfer(A, 1'b1, 8'h12, 8'hfb, q, v);
        // Setting shows one cycle after the answer
        @(posedge clk);
        #1;
        check("clamp", 8'hfa, filt);
        ctl_u.xfer(A, 1'b1, 8'h12, 8'h03, q, v);
        ctl_u.xfer(C, 1'b1, 8'h12, 8'h07, q, v);
        @(posedge clk);
        #1;
        check("filter", 8'h03, filt);
        @(posedge clk);
        din <= 8'hff;
        repeat (2) @(posedge clk);
        #1;
        check("held", 8'h3c, green);
        repeat (30) @(posedge clk);
        check("filtered", 8'hff, green);
        ctl_u.xfer(A, 1'b1, 8'h12, 8'h00, q, v);
        $display("filter done");
        ctl_u.xfer(C, 1'b1, 8'h00, 8'h01, q, v);
        @(posedge clk);
        m_ov <= 4'h1;
        m_ev <= 4'h2;
        m_np <= 4'h4;
        repeat (2) @(posedge clk);
        m_ov <= 4'h0;
        m_ev <= 4'h0;
        m_np <= 4'h0;
        ctl_u.xfer(C, 1'b0, 8'h02, 8'h00, q, v);
        check("fault", 8'h03, q);
        count_red();
        // Lit 3 of every 10 cycles, so 9 of any 30
        check("flash", 8'h09, cnt[7:0]);
        fm <= 8'hfe;
        ctl_u.xfer(C, 1'b0, 8'h02, 8'h00, q, v);
        check("bc fault cyclic", 8'h00, q);
        ctl_u.xfer(C, 1'b1, 8'h00, 8'h03, q, v);
        ctl_u.xfer(A, 1'b0, 8'h1e, 8'h00, q, v);
        check("fault kept", 8'h01, q);
        ctl_u.xfer(C, 1'b1, 8'h00, 8'h02, q, v);
        ctl_u.xfer(A, 1'b0, 8'h1e, 8'h00, q, v);
        check("fault cleared", 8'h00, q);
        repeat (15) @(posedge clk);
        count_red();
        check("red dark", 8'h00, cnt[7:0]);
        $display("faults done");
        // Leave a fault standing so reset has something to clear
        m_ov <= 4'h8;
        repeat (2) @(posedge clk);
        m_ov <= 4'h0;
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        check("dout", 8'h00, {4'h0, dout});
        check("red", 8'h00, {7'h0, red});
        rstn <= 1'b1;
        ctl_u.xfer(A, 1'b0, 8'h1e, 8'h00, q, v);
        check("fault reset", 8'h00, q);
        $display("reset done");
        print_verdict();
    end
endmodule
`default_nettype wire
